// ---- src/tmcfg_defs.svh ----
/*
  offsets, field positions, reset values and timing counts of the timing master
  configuration register bank; assumes an 8-bit register port and a 25 MHz clock.
*/
// Operation
// - inputs 1-4, 5-10, 12-14 rate defaults fixed
// - input eleven default from role strap
// - valid-control bit clear forces input invalid
// - forcing invalid leaves validity status untouched
// - high register covers inputs 9-14, top zero
// - soft reset bit holds device, restores defaults
// - soft reset reuses latched straps, no resample
// - loop state force field decoded to states
// - nonzero state force holds loop state
// - reference force codes select input or automatic
// - forced input selected now if revertive, else once current input invalid
// - forced reference never switched on invalidity
// - external frame sync gated by enables, lock
// - phase alarms auto clear after 127 to 128 seconds
// - oscillator edge bit selects rising/falling edge
// - manual holdover selects programmed holdover value
// - rate family bit sets code 0001 rate
// - role bit read-only mirror; slave forces settings
// - revertive replaces selected by higher priority input
// - slave mode reads revertive bit as one
// - link bit locks secondary; feedback mode bit
`ifndef TMCFG_DEFS_SVH
`define TMCFG_DEFS_SVH

`define TMCFG_ICR_BASE        8'h20
`define TMCFG_ICR_LAST        8'h2D
`define TMCFG_VALID_LOW       8'h30
`define TMCFG_VALID_HIGH      8'h31
`define TMCFG_CFG_RESET_STATE 8'h32
`define TMCFG_CFG_FORCE_REF   8'h33
`define TMCFG_CFG_MODES       8'h34
`define TMCFG_CFG_SECONDARY   8'h35

`define TMCFG_BIT_SOFT_RST    7
`define TMCFG_BIT_AUTO_FS     7
`define TMCFG_BIT_ALARM_TO    6
`define TMCFG_BIT_OSC_EDGE    5
`define TMCFG_BIT_MAN_HO      4
`define TMCFG_BIT_EXT_FS      3
`define TMCFG_BIT_RATE_FAM    2
`define TMCFG_BIT_ROLE        1
`define TMCFG_BIT_REVERT      0
`define TMCFG_BIT_LINK        7
`define TMCFG_BIT_DIG_FB      6
`define TMCFG_BIT_OUT_SRC     4

`define TMCFG_RST_VALID_LOW   8'hFF
`define TMCFG_RST_VALID_HIGH  6'h3F
`define TMCFG_RST_FORCE_REF   4'hF
`define TMCFG_RST_AUTO_FS     1'b1
`define TMCFG_RST_ALARM_TO    1'b1
`define TMCFG_RST_DIG_FB      1'b1
`define TMCFG_NOMINAL_RATE_FIELD_GRP_A      4'h0
`define TMCFG_NOMINAL_RATE_FIELD_GRP_B      4'h3
`define TMCFG_NOMINAL_RATE_FIELD_GRP_C      4'h1
`define TMCFG_NOMINAL_RATE_FIELD_IN11_SLAVE 4'h2
`define TMCFG_NOMINAL_RATE_FIELD_IN11_MAST  4'h3
`define TMCFG_REF_AUTO_LO     4'h0
`define TMCFG_REF_AUTO_HI     4'hF

`define TMCFG_CLK_PERIOD_NS   40
`define TMCFG_NS_PER_S        1000000000
`define TMCFG_SEC_CYCLES      (`TMCFG_NS_PER_S / `TMCFG_CLK_PERIOD_NS)
`define TMCFG_ALARM_TIMEOUT_S 128

`endif

// ---- src/tmcfg_pkg.sv ----
/*
  types of the timing master configuration register bank; assumes tmcfg_defs.svh
  supplies the numeric constants.
*/
package tmcfg_pkg;

  typedef enum logic [2:0] {
    TMCFG_LS_AUTO     = 3'h0,
    TMCFG_LS_FREE_RUN = 3'h1,
    TMCFG_LS_HOLDOVER = 3'h2,
    TMCFG_LS_UNUSED   = 3'h3,
    TMCFG_LS_LOCKED   = 3'h4,
    TMCFG_LS_PRELOCK2 = 3'h5,
    TMCFG_LS_PRELOCK  = 3'h6,
    TMCFG_LS_LOSS     = 3'h7
  } tmcfg_loop_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } tmcfg_bus_req_t;

  typedef struct packed {
    logic              device_reset;
    tmcfg_loop_state_t loop_state;
    logic              loop_state_hold;
    logic              revertive;
    logic              slave_mode;
    logic              in11_top_priority;
    logic              acq_bandwidth;
    logic              build_out_off;
    logic              ext_fs_use;
    logic              alarm_autoclear;
    logic              osc_fall_edge;
    logic              manual_holdover;
    logic              rate_1544;
    logic              link_secondary;
    logic              secondary_digital_fb;
    logic              out89_from_primary;
    logic [3:0]        secondary_force;
  } tmcfg_cfg_t;

endpackage

// ---- src/tmcfg_alarm_timer.sv ----
/*
  per-input phase alarm flags with optional timed self clear; assumes set and clear
  are one-cycle pulses synchronous to clk.
*/
`timescale 1ns/1ns
`default_nettype none
`include "tmcfg_defs.svh"
module tmcfg_alarm_timer
  import tmcfg_pkg::*;
#(
  parameter int unsigned N           = 14,
  parameter int unsigned TICK_CYCLES = `TMCFG_SEC_CYCLES,
  parameter int unsigned TIMEOUT_S   = `TMCFG_ALARM_TIMEOUT_S
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         hold,
  input  wire logic         autoclear,
  input  wire logic [N-1:0] set,
  input  wire logic [N-1:0] clear,
  output logic      [N-1:0] alarm_r
);

  initial begin
    if (TICK_CYCLES < 1 || TIMEOUT_S < 1 || TIMEOUT_S > 255)
      $error("tmcfg_alarm_timer: unsupported tick or timeout");
  end

  logic [31:0] tick_cnt_r;
  logic        tick;
  logic [7:0]  age_r [N];

  // one-second enable; a first partial second makes the timeout 127 to 128 s
  assign tick = (tick_cnt_r == 32'(TICK_CYCLES - 1));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_r <= 32'h0;
    end else if (hold || tick) begin
      tick_cnt_r <= 32'h0;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h1;
    end
  end

  for (genvar i = 0; i < N; i++) begin : g_alarm
    logic expire;
    assign expire = autoclear && tick && (age_r[i] == 8'(TIMEOUT_S - 1));
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        alarm_r[i] <= 1'b0;
        age_r[i]   <= 8'h0;
      end else if (hold) begin
        alarm_r[i] <= 1'b0;
        age_r[i]   <= 8'h0;
      end else if (set[i]) begin
        // a new alarm beats a clear in the same cycle and restarts its age
        alarm_r[i] <= 1'b1;
        age_r[i]   <= 8'h0;
      end else if (clear[i] || expire) begin
        alarm_r[i] <= 1'b0;
        age_r[i]   <= 8'h0;
      end else if (alarm_r[i] && tick && autoclear) begin
        age_r[i]   <= age_r[i] + 8'h1;
      end
    end

    a_alarm_sw_only: assert property (@(posedge clk) disable iff (!rst_n)
      $fell(alarm_r[i]) && !$past(autoclear) |-> $past(clear[i]) || $past(hold))
      else $error("alarm ended without clear while timeout off");
  end

endmodule // tmcfg_alarm_timer
`default_nettype wire

// ---- src/tmcfg_regs.sv ----
/*
  timing master configuration register bank: input valid controls, soft reset,
  loop state and reference forcing, mode bits, secondary path link, plus the
  per-input nominal rate fields; assumes an 8-bit register port with read data
  one cycle after the read strobe and straps stable around reset release.
*/
`timescale 1ns/1ns
`default_nettype none
`include "tmcfg_defs.svh"
module tmcfg_regs
  import tmcfg_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `TMCFG_SEC_CYCLES,
  parameter int unsigned TIMEOUT_S   = `TMCFG_ALARM_TIMEOUT_S
) (
  input  wire logic           clk,
  input  wire logic           rst_n,
  input  wire tmcfg_bus_req_t bus,
  input  wire logic           role_pin,
  input  wire logic           rate_family_pin,
  input  wire logic [13:0]    mon_valid,
  input  wire logic [3:0]     auto_best_ref,
  input  wire logic           loop_locked,
  input  wire logic [3:0]     fs_source,
  input  wire logic [13:0]    phase_alarm_set,
  input  wire logic [13:0]    phase_alarm_clear,
  output logic      [7:0]     rd_data_r,
  output tmcfg_cfg_t          cfg_r,
  output logic      [3:0]     sel_ref_r,
  output logic      [3:0]     top_entry_r,
  output logic      [13:0]    valid_eff_r,
  output logic      [13:0]    valid_status_r,
  output logic      [13:0]    phase_alarm,
  output logic      [55:0]    nominal_rate_r
);

  localparam int unsigned NUM_IN = 14;

  initial begin
    if (TICK_CYCLES < 1 || TIMEOUT_S < 1)
      $error("tmcfg_regs: tick and timeout must be at least one");
  end

  // storage
  logic [13:0] valid_ctrl_r;
  logic        soft_rst_r;
  logic [2:0]  state_force_r;
  logic [3:0]  ref_force_r;
  logic        auto_fs_r;
  logic        alarm_to_r;
  logic        osc_edge_r;
  logic        man_ho_r;
  logic        ext_fs_r;
  logic        rate_fam_r;
  logic        revert_r;
  logic        link_r;
  logic        dig_fb_r;
  logic        out_src_r;
  logic [3:0]  sec_force_r;
  logic [3:0]  nominal_rate_field_r [NUM_IN];
  logic        role_strap_r;
  logic        rate_strap_r;
  logic [1:0]  init_r;

  logic        load_defs;
  logic        force_on;
  logic        revert_eff;
  logic        cur_ok;
  logic        wr_valid_lo;
  logic        wr_valid_hi;
  logic        wr_state;
  logic        wr_force;
  logic        wr_modes;
  logic        wr_second;

  // straps follow their pins while the reset pin is low; defaults load on the second edge after release
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      init_r <= 2'h0;
    end else if (init_r != 2'h2) begin
      init_r <= init_r + 2'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      role_strap_r <= role_pin;
      rate_strap_r <= rate_family_pin;
    end
  end

  // soft reset holds every field except its own bit at its default
  assign load_defs = soft_rst_r || (init_r == 2'h1);

  assign wr_valid_lo = bus.wr && (bus.addr == `TMCFG_VALID_LOW);
  assign wr_valid_hi = bus.wr && (bus.addr == `TMCFG_VALID_HIGH);
  assign wr_state    = bus.wr && (bus.addr == `TMCFG_CFG_RESET_STATE);
  assign wr_force    = bus.wr && (bus.addr == `TMCFG_CFG_FORCE_REF);
  assign wr_modes    = bus.wr && (bus.addr == `TMCFG_CFG_MODES);
  assign wr_second   = bus.wr && (bus.addr == `TMCFG_CFG_SECONDARY);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      soft_rst_r <= 1'b0;
    end else if (wr_state) begin
      soft_rst_r <= bus.wdata[`TMCFG_BIT_SOFT_RST];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      valid_ctrl_r <= {`TMCFG_RST_VALID_HIGH, `TMCFG_RST_VALID_LOW};
    end else if (load_defs) begin
      valid_ctrl_r <= {`TMCFG_RST_VALID_HIGH, `TMCFG_RST_VALID_LOW};
    end else begin
      if (wr_valid_lo) begin
        valid_ctrl_r[7:0] <= bus.wdata;
      end
      if (wr_valid_hi) begin
        valid_ctrl_r[13:8] <= bus.wdata[5:0];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_force_r <= 3'h0;
      ref_force_r   <= `TMCFG_RST_FORCE_REF;
    end else if (load_defs) begin
      state_force_r <= 3'h0;
      ref_force_r   <= `TMCFG_RST_FORCE_REF;
    end else begin
      if (wr_state) begin
        state_force_r <= bus.wdata[2:0];
      end
      if (wr_force) begin
        ref_force_r <= bus.wdata[3:0];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      auto_fs_r  <= `TMCFG_RST_AUTO_FS;
      alarm_to_r <= `TMCFG_RST_ALARM_TO;
      osc_edge_r <= 1'b0;
      man_ho_r   <= 1'b0;
      ext_fs_r   <= 1'b0;
      rate_fam_r <= 1'b0;
      revert_r   <= 1'b0;
    end else if (load_defs) begin
      auto_fs_r  <= `TMCFG_RST_AUTO_FS;
      alarm_to_r <= `TMCFG_RST_ALARM_TO;
      osc_edge_r <= 1'b0;
      man_ho_r   <= 1'b0;
      ext_fs_r   <= 1'b0;
      rate_fam_r <= rate_strap_r;
      revert_r   <= 1'b0;
    end else if (wr_modes) begin
      auto_fs_r  <= bus.wdata[`TMCFG_BIT_AUTO_FS];
      alarm_to_r <= bus.wdata[`TMCFG_BIT_ALARM_TO];
      osc_edge_r <= bus.wdata[`TMCFG_BIT_OSC_EDGE];
      man_ho_r   <= bus.wdata[`TMCFG_BIT_MAN_HO];
      ext_fs_r   <= bus.wdata[`TMCFG_BIT_EXT_FS];
      rate_fam_r <= bus.wdata[`TMCFG_BIT_RATE_FAM];
      // stored even in slave mode so it takes effect once the role changes
      revert_r   <= bus.wdata[`TMCFG_BIT_REVERT];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      link_r      <= 1'b0;
      dig_fb_r    <= `TMCFG_RST_DIG_FB;
      out_src_r   <= 1'b0;
      sec_force_r <= 4'h0;
    end else if (load_defs) begin
      link_r      <= 1'b0;
      dig_fb_r    <= `TMCFG_RST_DIG_FB;
      out_src_r   <= 1'b0;
      sec_force_r <= 4'h0;
    end else if (wr_second) begin
      link_r      <= bus.wdata[`TMCFG_BIT_LINK];
      dig_fb_r    <= bus.wdata[`TMCFG_BIT_DIG_FB];
      out_src_r   <= bus.wdata[`TMCFG_BIT_OUT_SRC];
      sec_force_r <= bus.wdata[3:0];
    end
  end

  // per-input nominal rate fields
  for (genvar i = 0; i < NUM_IN; i++) begin : g_nominal_rate_field
    logic [3:0] def;
    always_comb begin
      if (i < 4) begin
        def = `TMCFG_NOMINAL_RATE_FIELD_GRP_A;
      end else if (i < 10) begin
        def = `TMCFG_NOMINAL_RATE_FIELD_GRP_B;
      end else if (i == 10) begin
        def = role_strap_r ? `TMCFG_NOMINAL_RATE_FIELD_IN11_MAST : `TMCFG_NOMINAL_RATE_FIELD_IN11_SLAVE;
      end else begin
        def = `TMCFG_NOMINAL_RATE_FIELD_GRP_C;
      end
    end
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        nominal_rate_field_r[i] <= 4'h0;
      end else if (load_defs) begin
        nominal_rate_field_r[i] <= def;
      end else if (bus.wr && bus.addr == (`TMCFG_ICR_BASE + 8'(i))) begin
        nominal_rate_field_r[i] <= bus.wdata[3:0];
      end
    end
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        nominal_rate_r[4*i +: 4] <= 4'h0;
      end else begin
        nominal_rate_r[4*i +: 4] <= nominal_rate_field_r[i];
      end
    end
  end

  // validity: status passes the monitors through, the mask only feeds selection
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      valid_status_r <= 14'h0;
      valid_eff_r    <= 14'h0;
    end else begin
      valid_status_r <= mon_valid;
      valid_eff_r    <= mon_valid & valid_ctrl_r;
    end
  end

  // reference selection
  assign force_on   = (ref_force_r != `TMCFG_REF_AUTO_LO) && (ref_force_r != `TMCFG_REF_AUTO_HI);
  assign revert_eff = revert_r || !role_pin;
  assign cur_ok     = (sel_ref_r != 4'h0) && valid_eff_r[sel_ref_r - 4'h1];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_ref_r <= 4'h0;
    end else if (load_defs) begin
      sel_ref_r <= 4'h0;
    end else if (force_on) begin
      // once on the forced input it stays there even when declared invalid
      if (sel_ref_r != ref_force_r && (revert_eff || !cur_ok)) begin
        sel_ref_r <= ref_force_r;
      end
    end else if (sel_ref_r != auto_best_ref && (revert_eff || !cur_ok)) begin
      sel_ref_r <= auto_best_ref;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      top_entry_r <= 4'h0;
    end else begin
      top_entry_r <= force_on ? ref_force_r : auto_best_ref;
    end
  end

  // mode outputs to the loops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_r <= '0;
    end else begin
      cfg_r.device_reset         <= soft_rst_r;
      cfg_r.loop_state           <= tmcfg_loop_state_t'(state_force_r);
      cfg_r.loop_state_hold      <= (state_force_r != 3'h0);
      cfg_r.revertive            <= revert_eff;
      cfg_r.slave_mode           <= !role_pin;
      cfg_r.in11_top_priority    <= !role_pin;
      cfg_r.acq_bandwidth        <= !role_pin;
      cfg_r.build_out_off        <= !role_pin;
      cfg_r.ext_fs_use           <= ext_fs_r && (!auto_fs_r || (loop_locked && sel_ref_r == fs_source));
      cfg_r.alarm_autoclear      <= alarm_to_r;
      cfg_r.osc_fall_edge        <= osc_edge_r;
      cfg_r.manual_holdover      <= man_ho_r;
      cfg_r.rate_1544            <= rate_fam_r;
      cfg_r.link_secondary       <= link_r;
      cfg_r.secondary_digital_fb <= dig_fb_r;
      cfg_r.out89_from_primary   <= out_src_r;
      cfg_r.secondary_force      <= sec_force_r;
    end
  end

  tmcfg_alarm_timer #(
    .N           (NUM_IN),
    .TICK_CYCLES (TICK_CYCLES),
    .TIMEOUT_S   (TIMEOUT_S)
  ) u_alarm (
    .clk       (clk),
    .rst_n     (rst_n),
    .hold      (soft_rst_r),
    .autoclear (alarm_to_r),
    .set       (phase_alarm_set),
    .clear     (phase_alarm_clear),
    .alarm_r   (phase_alarm)
  );

  // read port; reserved bits read zero, unmapped addresses read zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_r <= 8'h00;
    end else if (bus.rd) begin
      if (bus.addr >= `TMCFG_ICR_BASE && bus.addr <= `TMCFG_ICR_LAST) begin
        rd_data_r <= {4'h0, nominal_rate_field_r[4'(bus.addr - `TMCFG_ICR_BASE)]};
      end else begin
        unique case (bus.addr)
          `TMCFG_VALID_LOW:       rd_data_r <= valid_ctrl_r[7:0];
          `TMCFG_VALID_HIGH:      rd_data_r <= {2'h0, valid_ctrl_r[13:8]};
          `TMCFG_CFG_RESET_STATE: rd_data_r <= {soft_rst_r, 4'h0, state_force_r};
          `TMCFG_CFG_FORCE_REF:   rd_data_r <= {4'h0, ref_force_r};
          `TMCFG_CFG_MODES:       rd_data_r <= {auto_fs_r, alarm_to_r, osc_edge_r, man_ho_r, ext_fs_r, rate_fam_r,
                                                role_pin, revert_r || !role_pin};
          `TMCFG_CFG_SECONDARY:   rd_data_r <= {link_r, dig_fb_r, 1'b0, out_src_r, sec_force_r};
          default:                rd_data_r <= 8'h00;
        endcase
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_soft_rst_defs: assert property (soft_rst_r |=> ref_force_r == `TMCFG_RST_FORCE_REF
    && valid_ctrl_r == 14'h3FFF && state_force_r == 3'h0 && dig_fb_r)
    else $error("soft reset did not restore defaults");
  a_in11_strap: assert property (soft_rst_r |=> nominal_rate_field_r[10] == (role_strap_r ? 4'h3 : 4'h2))
    else $error("input eleven default not from latched strap");
  a_valid_mask: assert property (rst_n |=> valid_eff_r == $past(mon_valid & valid_ctrl_r))
    else $error("effective validity not masked by control");
  a_status_pass: assert property (rst_n |=> valid_status_r == $past(mon_valid))
    else $error("validity status altered by control");
  a_state_hold: assert property (state_force_r != 3'h0 |=> cfg_r.loop_state_hold
    && cfg_r.loop_state == tmcfg_loop_state_t'($past(state_force_r)))
    else $error("forced loop state not presented");
  a_force_revert: assert property (force_on && revert_eff && !load_defs |=> sel_ref_r == $past(ref_force_r))
    else $error("forced input not selected in revertive mode");
  a_force_stays: assert property (force_on && sel_ref_r == ref_force_r && !load_defs
    && $stable(ref_force_r) |=> $stable(sel_ref_r))
    else $error("forced reference switched away");
  a_fs_gate: assert property (cfg_r.ext_fs_use |-> $past(ext_fs_r))
    else $error("frame sync used while disabled");
  a_role_mirror: assert property (bus.rd && bus.addr == `TMCFG_CFG_MODES |=> rd_data_r[1] == $past(role_pin))
    else $error("role bit does not mirror pin");
  a_slave_revert: assert property (bus.rd && bus.addr == `TMCFG_CFG_MODES && !role_pin |=> rd_data_r[0])
    else $error("slave mode revertive bit not read as one");
  a_rsvd_zero: assert property (bus.rd && bus.addr == `TMCFG_VALID_HIGH |=> rd_data_r[7:6] == 2'h0)
    else $error("reserved bits not zero");

  c_soft_reset: cover property (wr_state && bus.wdata[7] ##1 soft_rst_r);
  c_force_sel:  cover property (force_on ##1 sel_ref_r == ref_force_r);
  c_nonrev_hold: cover property (force_on && !revert_eff && cur_ok && sel_ref_r != ref_force_r);
  c_fs_on:      cover property (cfg_r.ext_fs_use && auto_fs_r);

endmodule // tmcfg_regs
`default_nettype wire

// ---- dv/tmcfg_regs_bench.sv ----
/*
  self-checking bench of the timing master configuration bank: register table rows in one loop,
  then selection, frame sync, alarm timeout, state force, soft reset and slave mode by hand.
  assumes the design files and package are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
module tmcfg_regs_bench
  import tmcfg_pkg::*;
;
  typedef struct packed {logic wr; logic [7:0] addr; logic [7:0] wdata; logic [7:0] exp;} tmcfg_row_t;
  logic           clk, rst_n, role_pin, rate_family_pin, loop_locked;
  tmcfg_bus_req_t bus;
  logic [13:0]    mon_valid, phase_alarm_set, phase_alarm_clear, valid_eff_r, valid_status_r, phase_alarm;
  logic [3:0]     auto_best_ref, fs_source, sel_ref_r, top_entry_r;
  logic [7:0]     rd_data_r;
  tmcfg_cfg_t     cfg_r;
  logic [55:0]    nominal_rate_r;
  int             fail_count, checks_done, cycles;
  // role strap high and rate strap high at reset, so input eleven and mode register use those
  tmcfg_row_t     rows [0:18] = '{
    {1'b0, 8'h20, 8'h00, 8'h00}, {1'b0, 8'h23, 8'h00, 8'h00}, {1'b0, 8'h24, 8'h00, 8'h03},
    {1'b0, 8'h29, 8'h00, 8'h03}, {1'b0, 8'h2A, 8'h00, 8'h03}, {1'b0, 8'h2B, 8'h00, 8'h01},
    {1'b0, 8'h2D, 8'h00, 8'h01}, {1'b0, 8'h30, 8'h00, 8'hFF}, {1'b0, 8'h31, 8'h00, 8'h3F},
    {1'b0, 8'h32, 8'h00, 8'h00}, {1'b0, 8'h33, 8'h00, 8'h0F}, {1'b0, 8'h34, 8'h00, 8'hC6},
    {1'b0, 8'h35, 8'h00, 8'h40}, {1'b0, 8'h40, 8'h00, 8'h00}, {1'b1, 8'h31, 8'hFF, 8'h3F},
    {1'b1, 8'h34, 8'h3D, 8'h3F}, {1'b1, 8'h35, 8'hFF, 8'hDF}, {1'b1, 8'h32, 8'h7B, 8'h03},
    {1'b1, 8'h40, 8'h55, 8'h00}};

  tmcfg_regs #(.TICK_CYCLES(4), .TIMEOUT_S(3)) dut (
    .clk(clk), .rst_n(rst_n), .bus(bus), .role_pin(role_pin), .rate_family_pin(rate_family_pin),
    .mon_valid(mon_valid), .auto_best_ref(auto_best_ref), .loop_locked(loop_locked), .fs_source(fs_source),
    .phase_alarm_set(phase_alarm_set), .phase_alarm_clear(phase_alarm_clear), .rd_data_r(rd_data_r),
    .cfg_r(cfg_r), .sel_ref_r(sel_ref_r), .top_entry_r(top_entry_r), .valid_eff_r(valid_eff_r),
    .valid_status_r(valid_status_r), .phase_alarm(phase_alarm), .nominal_rate_r(nominal_rate_r));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) bus <= {a, d, 1'b1, 1'b0};
    @(posedge clk) bus <= '0;
  endtask

  // read data appear in the cycle after the strobe and hold until the next read; sample at that cycle's falling edge
  task rd_reg(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk) bus <= {a, 8'h00, 1'b0, 1'b1};
    @(posedge clk) bus <= '0;
    @(negedge clk) chk(rd_data_r, e);
  endtask

  task idle(input int n);
    repeat (n) @(negedge clk);
  endtask

  task print_verdict;
    $display("checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fail_count++;
      print_verdict();
    end
  end

  initial begin
    rst_n = 1'b0; role_pin = 1'b1; rate_family_pin = 1'b1; loop_locked = 1'b0; bus = '0;
    mon_valid = 14'h3FFF; auto_best_ref = 4'h2; fs_source = 4'h2;
    phase_alarm_set = '0; phase_alarm_clear = '0; cycles = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk({4'h0, nominal_rate_r[43:40]}, 8'h03);
    foreach (rows[i]) begin
      if (rows[i].wr) wr_reg(rows[i].addr, rows[i].wdata);
      rd_reg(rows[i].addr, rows[i].exp);
    end
    chk({3'h0, cfg_r.osc_fall_edge, cfg_r.manual_holdover, cfg_r.rate_1544, cfg_r.link_secondary,
         cfg_r.secondary_digital_fb}, 8'h1F);
    chk({2'h0, cfg_r.out89_from_primary, cfg_r.alarm_autoclear, cfg_r.secondary_force}, 8'h2F);
    wr_reg(8'h30, 8'hEF);
    idle(3);
    chk({6'h0, valid_eff_r[4], valid_status_r[4]}, 8'h01);
    wr_reg(8'h30, 8'hFF);
    wr_reg(8'h33, 8'h05);
    idle(3);
    chk({sel_ref_r, top_entry_r}, 8'h55);
    wr_reg(8'h34, 8'h04);
    wr_reg(8'h33, 8'h07);
    idle(3);
    chk({4'h0, sel_ref_r}, 8'h05);
    wr_reg(8'h30, 8'hEF);
    idle(4);
    chk({4'h0, sel_ref_r}, 8'h07);
    wr_reg(8'h30, 8'hFF);
    wr_reg(8'h34, 8'h45);
    wr_reg(8'h33, 8'h0F);
    idle(3);
    chk({4'h0, sel_ref_r}, 8'h02);
    wr_reg(8'h33, 8'h02);
    mon_valid <= 14'h3FFD;
    auto_best_ref <= 4'h3;
    idle(4);
    chk({4'h0, sel_ref_r}, 8'h02);
    wr_reg(8'h34, 8'hCD);
    idle(3);
    chk({7'h0, cfg_r.ext_fs_use}, 8'h00);
    loop_locked <= 1'b1;
    idle(3);
    chk({7'h0, cfg_r.ext_fs_use}, 8'h01);
    @(posedge clk) phase_alarm_set <= 14'h0001;
    @(posedge clk) phase_alarm_set <= '0;
    idle(6);
    chk({7'h0, phase_alarm[0]}, 8'h01);
    idle(10);
    chk({7'h0, phase_alarm[0]}, 8'h00);
    wr_reg(8'h34, 8'h8D);
    @(posedge clk) phase_alarm_set <= 14'h0001;
    @(posedge clk) phase_alarm_set <= '0;
    idle(20);
    chk({7'h0, phase_alarm[0]}, 8'h01);
    @(posedge clk) phase_alarm_clear <= 14'h0001;
    @(posedge clk) phase_alarm_clear <= '0;
    idle(2);
    chk({7'h0, phase_alarm[0]}, 8'h00);
    for (int c = 0; c < 8; c++) begin
      wr_reg(8'h32, c[7:0]);
      idle(2);
      chk({4'h0, cfg_r.loop_state, cfg_r.loop_state_hold}, {4'h0, c[2:0], c != 0});
    end
    // strap now low: a soft reset must still restore the value latched at hardware reset
    rate_family_pin <= 1'b0;
    wr_reg(8'h33, 8'h05);
    wr_reg(8'h32, 8'h80);
    idle(2);
    chk({7'h0, cfg_r.device_reset}, 8'h01);
    wr_reg(8'h33, 8'h09);
    rd_reg(8'h33, 8'h0F);
    wr_reg(8'h32, 8'h00);
    rd_reg(8'h34, 8'hC6);
    rd_reg(8'h32, 8'h00);
    role_pin <= 1'b0;
    wr_reg(8'h34, 8'h00);
    rd_reg(8'h34, 8'h01);
    idle(2);
    chk({3'h0, cfg_r.acq_bandwidth, cfg_r.build_out_off, cfg_r.revertive, cfg_r.slave_mode,
         cfg_r.in11_top_priority}, 8'h1F);
    print_verdict();
  end
endmodule // tmcfg_regs_bench
`default_nettype wire
